// >>> design/ivsr_top.sv
// Purpose: Command handler for version, status, status-clear and device reset
// Assumes: A front end delivers 16-bit command codes and pulls response bytes
// Notes:   Responses become readable after the read delay; reset holds the core
`timescale 1ns/1ps
module ivsr_top #(
    parameter logic [31:0] STICKY_MASK    = 32'hFFFF0000,
    parameter int          READ_DELAY_CYC = ivsr_pkg::READ_DELAY_CYC,
    parameter int          RESET_HOLD_CYC = ivsr_pkg::RESET_HOLD_CYC,
    parameter logic [7:0]  FW_MAJOR       = 8'h01,
    parameter logic [7:0]  FW_MINOR       = 8'h00,
    parameter logic [7:0]  FW_DEBUG       = 8'h00,
    parameter logic [7:0]  HW_MAJOR       = 8'h01,
    parameter logic [7:0]  HW_MINOR       = 8'h00,
    parameter logic [7:0]  PROTO_MAJOR    = 8'h01,
    parameter logic [7:0]  PROTO_MINOR    = 8'h00
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_cmd_valid,
    input  wire logic [15:0]          i_cmd_code,
    input  wire logic [31:0]          i_status_cond,
    input  wire logic                 i_rd_req,
    output logic                      o_cmd_ready,
    output ivsr_pkg::ivsr_byte_s      o_rd,
    output logic                      o_resp_ready,
    output logic                      o_unknown_cmd,
    output logic                      o_dev_reset
);
    // Core state
    ivsr_pkg::ivsr_state_e state;
    ivsr_pkg::ivsr_state_e next_state;
    logic [31:0]           timer;
    logic [31:0]           next_timer;
    logic [63:0]           payload;
    logic [3:0]            resp_len;
    logic [3:0]            idx;
    logic [1:0]            phase;
    logic                  unknown;
    ivsr_pkg::ivsr_byte_s  rd;
    logic                  soft_rst;
    logic                  core_rst_b;
    logic [31:0]           status_word;
    logic [7:0]            crc;

    // Decode (codes are bare 16 bits, no checksum follows)
    wire cmd_take   = i_cmd_valid && (state != ivsr_pkg::ST_RESET);
    wire is_version = i_cmd_code == ivsr_pkg::CMD_VERSION;
    wire is_status  = i_cmd_code == ivsr_pkg::CMD_STATUS;
    wire is_sclear  = i_cmd_code == ivsr_pkg::CMD_STATUS_CLEAR;
    wire is_reset   = i_cmd_code == ivsr_pkg::CMD_RESET;
    wire known      = is_version | is_status | is_sclear | is_reset;
    wire do_clear   = cmd_take && is_sclear;

    // Version payload in transmit order
    ivsr_pkg::ivsr_version_s ver;
    assign ver = '{fw_major: FW_MAJOR, fw_minor: FW_MINOR,
                   fw_debug: FW_DEBUG, hw_major: HW_MAJOR,
                   hw_minor: HW_MINOR, proto_major: PROTO_MAJOR,
                   proto_minor: PROTO_MINOR, padding: 8'h00};

    // Full device reset covers the status latches too
    assign core_rst_b = i_rst_b && !soft_rst;

    ivsr_status #(
        .STICKY_MASK (STICKY_MASK)
    ) u_status (
        .i_clk    (i_clk),
        .i_rst_b  (core_rst_b),
        .i_cond   (i_status_cond),
        .i_clear  (do_clear),
        .o_status (status_word)
    );

    // Byte stream: two data bytes then CRC; phase 2 marks a CRC slot
    wire       in_send   = state == ivsr_pkg::ST_SEND;
    wire       pull      = in_send && i_rd_req;
    wire       crc_slot  = phase == 2'd2;
    wire [7:0] data_byte = payload[63:56];
    wire [7:0] out_byte  = crc_slot ? crc : data_byte;
    wire       last_byte = idx == resp_len - 4'd1;

    ivsr_crc8 u_crc (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_clear (!in_send || (pull && crc_slot)),
        .i_en    (pull && !crc_slot),
        .i_data  (data_byte),
        .o_crc   (crc)
    );

    // Next state and timer
    always_comb begin
        next_state = state;
        next_timer = timer;
        case (state)
            ivsr_pkg::ST_IDLE, ivsr_pkg::ST_WAIT, ivsr_pkg::ST_SEND: begin
                if (state == ivsr_pkg::ST_WAIT) begin
                    if (timer == 32'd0) begin
                        next_state = ivsr_pkg::ST_SEND;
                    end else begin
                        next_timer = timer - 32'd1;
                    end
                end
                if (pull && last_byte) begin
                    next_state = ivsr_pkg::ST_IDLE;
                end
                if (cmd_take && is_reset) begin
                    next_state = ivsr_pkg::ST_RESET;
                    next_timer = 32'(RESET_HOLD_CYC - 1);
                end else if (cmd_take && (is_version || is_status || is_sclear)) begin
                    next_state = ivsr_pkg::ST_WAIT;
                    next_timer = 32'(READ_DELAY_CYC - 1);
                end
            end
            ivsr_pkg::ST_RESET: begin
                if (timer == 32'd0) begin
                    next_state = ivsr_pkg::ST_IDLE;
                end else begin
                    next_timer = timer - 32'd1;
                end
            end
            default: begin
                next_state = ivsr_pkg::ST_IDLE;
            end
        endcase
    end

    // State, timer and soft reset pulse
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state    <= ivsr_pkg::ST_IDLE;
            timer    <= 32'd0;
            soft_rst <= 1'b0;
        end else begin
            state    <= next_state;
            timer    <= next_timer;
            soft_rst <= cmd_take && is_reset;
        end
    end

    // Capture payload at command, shift out per data byte
    always_ff @(posedge i_clk) begin
        if (!core_rst_b) begin
            payload  <= 64'h0;
            resp_len <= 4'h0;
            idx      <= 4'h0;
            phase    <= 2'd0;
        end else if (cmd_take && is_version) begin
            payload  <= ver;
            resp_len <= ivsr_pkg::LEN_VERSION;
            idx      <= 4'h0;
            phase    <= 2'd0;
        end else if (cmd_take && (is_status || is_sclear)) begin
            payload  <= {status_word, 32'h0};
            resp_len <= ivsr_pkg::LEN_STATUS;
            idx      <= 4'h0;
            phase    <= 2'd0;
        end else if (pull) begin
            idx   <= idx + 4'd1;
            phase <= crc_slot ? 2'd0 : phase + 2'd1;
            if (!crc_slot) begin
                payload <= {payload[55:0], 8'h00};
            end
        end
    end

    // Registered output byte and flags
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd      <= '0;
            unknown <= 1'b0;
        end else begin
            rd.valid <= pull;
            rd.last  <= pull && last_byte;
            rd.data  <= pull ? out_byte : 8'h00;
            unknown  <= i_cmd_valid && !known && (state != ivsr_pkg::ST_RESET);
        end
    end

    assign o_rd          = rd;
    assign o_cmd_ready   = state != ivsr_pkg::ST_RESET;
    assign o_resp_ready  = in_send;
    assign o_unknown_cmd = unknown;
    assign o_dev_reset   = state == ivsr_pkg::ST_RESET;
endmodule

// >>> design/ivsr_pkg.sv
// Purpose: Shared constants and types for the version/status/reset command handler
// Assumes: Clock of 125 MHz; commands arrive already deframed as 16-bit codes
// Notes:   Byte streams are handed out one byte at a time, CRC bytes inserted by ivsr_top
package ivsr_pkg;

    // Command codes
    localparam logic [15:0] CMD_VERSION      = 16'hD100;
    localparam logic [15:0] CMD_STATUS       = 16'hD206;
    localparam logic [15:0] CMD_STATUS_CLEAR = 16'hD210;
    localparam logic [15:0] CMD_RESET        = 16'hD304;

    // CRC properties
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hFF;

    // Response lengths in bytes, CRC included
    localparam logic [3:0] LEN_VERSION = 4'hC;
    localparam logic [3:0] LEN_STATUS  = 4'h6;
    // Payload data bytes per response (CRC excluded)
    localparam int DATA_VERSION = 8;
    localparam int DATA_STATUS  = 4;

    // Read delay and reset hold time
    localparam int  CLK_MHZ          = 125;
    localparam int  READ_DELAY_MS    = 20;
    localparam int  RESET_HOLD_MS    = 1200;
    localparam int  READ_DELAY_CYC   = READ_DELAY_MS * 1000 * CLK_MHZ;
    localparam int  RESET_HOLD_CYC   = RESET_HOLD_MS * 1000 * CLK_MHZ;

    // Version payload (defaults, overridable by top parameters)
    typedef struct packed {
        logic [7:0] fw_major;
        logic [7:0] fw_minor;
        logic [7:0] fw_debug;
        logic [7:0] hw_major;
        logic [7:0] hw_minor;
        logic [7:0] proto_major;
        logic [7:0] proto_minor;
        logic [7:0] padding;
    } ivsr_version_s;

    // Outgoing response byte
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } ivsr_byte_s;

    // Handler states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_SEND  = 2'b10,
        ST_RESET = 2'b11
    } ivsr_state_e;

endpackage

// >>> design/ivsr_crc8.sv
// Purpose: Running CRC-8 over a word's two data bytes
// Assumes: Caller clears before each word's first byte
// Notes:   Polynomial and seed from the package, no reflection, no final xor
`timescale 1ns/1ps
module ivsr_crc8 (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_clear,
    input  wire logic       i_en,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_crc
);
    logic [7:0] crc;
    logic [7:0] next_crc;

    // One byte of MSB-first CRC
    function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ ivsr_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // Seed on clear, fold byte when enabled
    assign next_crc = i_clear ? ivsr_pkg::CRC_INIT : (i_en ? crc_byte(crc, i_data) : crc);
    assign o_crc    = crc;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            crc <= ivsr_pkg::CRC_INIT;
        end else begin
            crc <= next_crc;
        end
    end
endmodule

// >>> design/ivsr_status.sv
// Purpose: 32-bit device status word with sticky error bits and live bits
// Assumes: Condition inputs are on i_clk
// Notes:   A new error arriving with the clear still sets its bit
`timescale 1ns/1ps
module ivsr_status #(
    parameter logic [31:0] STICKY_MASK = 32'hFFFF0000
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic [31:0] i_cond,
    input  wire logic        i_clear,
    output logic      [31:0] o_status
);
    logic [31:0] sticky;
    logic [31:0] next_sticky;

    // Errors held until clear, set wins over clear
    assign next_sticky = ((i_clear ? 32'h0000_0000 : sticky) | i_cond) & STICKY_MASK;
    // Flags are plain OR of every bit, no priority
    assign o_status    = sticky | (i_cond & ~STICKY_MASK);

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sticky <= 32'h0000_0000;
        end else begin
            sticky <= next_sticky;
        end
    end
endmodule

// >>> bench/ivsr_checker.sv
// Purpose: Port-level assertions for the command handler
// Assumes: Read delay 10 and reset hold 20 cycles, as the bench sets them
// Notes:   Sees only the top ports, bound below
`timescale 1ns/1ps
module ivsr_checker (
    input wire logic                 i_clk,
    input wire logic                 i_rst_b,
    input wire logic                 i_cmd_valid,
    input wire logic [15:0]          i_cmd_code,
    input wire logic                 i_rd_req,
    input wire logic                 o_cmd_ready,
    input wire ivsr_pkg::ivsr_byte_s o_rd,
    input wire logic                 o_resp_ready,
    input wire logic                 o_dev_reset
);
    localparam int RDY = 11;
    localparam int GONE = 22;
    // Taken commands split into reading commands and device reset
    wire logic take = i_cmd_valid && o_cmd_ready;
    wire logic rsp = take && (i_cmd_code == ivsr_pkg::CMD_VERSION
        || i_cmd_code == ivsr_pkg::CMD_STATUS || i_cmd_code == ivsr_pkg::CMD_STATUS_CLEAR);
    wire logic rst = take && i_cmd_code == ivsr_pkg::CMD_RESET;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_ready_delay: assert property (rsp |-> ##RDY o_resp_ready)
        else $error("response not readable after the read delay");
    a_ready_quiet: assert property (rsp |=> !o_resp_ready [*8])
        else $error("response readable too early");
    a_dev_hold: assert property (rst |=> (o_dev_reset && !o_cmd_ready) [*8])
        else $error("device reset hold missing");
    a_dev_end: assert property (rst |-> ##GONE !o_dev_reset)
        else $error("device reset hold too long");
    // A command taken during the hold would make a response readable RDY cycles on
    a_cmd_block: assert property (o_dev_reset |-> ##RDY !o_resp_ready)
        else $error("commands accepted during reset hold");
    a_pull_answer: assert property (i_rd_req && o_resp_ready |=> o_rd.valid)
        else $error("pulled byte not returned");
    a_no_stray: assert property (!(i_rd_req && o_resp_ready) |=> !o_rd.valid)
        else $error("byte returned without a pull");
    a_last_drop: assert property (o_rd.valid && o_rd.last |-> !o_resp_ready)
        else $error("response still readable after last byte");
    a_ready_hold: assert property (o_resp_ready && !i_rd_req && !i_cmd_valid
        |=> o_resp_ready)
        else $error("response withdrawn without cause");
endmodule
bind ivsr_top ivsr_checker u_chk (.i_clk, .i_rst_b, .i_cmd_valid, .i_cmd_code, .i_rd_req,
    .o_cmd_ready, .o_rd, .o_resp_ready, .o_dev_reset);

// >>> bench/ivsr_host.sv
// Purpose: Host side model that pulls response bytes
// Assumes: Pulls change 1 ns after the clock edge
// Notes:   Stall input leaves idle cycles between pulls
`timescale 1ns/1ps
module ivsr_host (
    input  wire logic                 i_clk,
    input  wire logic                 i_resp_ready,
    input  wire ivsr_pkg::ivsr_byte_s i_rd,
    input  wire logic                 i_stall,
    input  wire logic                 i_clr,
    output logic                      o_rd_req,
    output logic [7:0]                o_buf [12],
    output int                        o_cnt
);
    initial o_rd_req = 1'b0;
    // Pull one byte a cycle while a response is readable
    always @(posedge i_clk) begin
        #1 o_rd_req = i_resp_ready && !i_stall;
    end
    // Store returned bytes in arrival order
    always @(posedge i_clk) begin
        if (i_clr) o_cnt <= 0;
        else if (i_rd.valid && o_cnt < 12) begin
            o_buf[o_cnt] <= i_rd.data;
            o_cnt <= o_cnt + 1;
        end
    end
endmodule

// >>> bench/ivsr_top_tb.sv
// Purpose: Self-checking bench for the command handler
// Assumes: Shortened read delay and reset hold
// Notes:   Host model pulls the bytes, the bench checks them
`timescale 1ns/1ps
module ivsr_top_tb;
    localparam logic [31:0] MASK     = 32'hFFFF0000;
    localparam int          RDY_CYC  = 10;
    localparam int          HOLD_CYC = 20;
    // Version numbers the instance reports, in transmit order
    localparam ivsr_pkg::ivsr_version_s VER = '{fw_major: 8'h03, fw_minor: 8'h2A,
        fw_debug: 8'h01, hw_major: 8'h05, hw_minor: 8'hC1, proto_major: 8'h02,
        proto_minor: 8'h07, padding: 8'h00};
    logic                 clk, rst_b, cmd_valid, stall, clr, rd_req;
    logic                 cmd_ready, resp_ready, unk, dev_rst;
    logic [15:0]          code;
    logic [31:0]          cond, sticky;
    ivsr_pkg::ivsr_byte_s rd;
    logic [7:0]           rx [12];
    logic [7:0]           ver [12];
    int                   cnt, miscompares, checked, seed, i;
    ivsr_top #(.STICKY_MASK(MASK), .READ_DELAY_CYC(RDY_CYC), .RESET_HOLD_CYC(HOLD_CYC),
        .FW_MAJOR(VER.fw_major), .FW_MINOR(VER.fw_minor), .FW_DEBUG(VER.fw_debug),
        .HW_MAJOR(VER.hw_major), .HW_MINOR(VER.hw_minor), .PROTO_MAJOR(VER.proto_major),
        .PROTO_MINOR(VER.proto_minor)) dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_cmd_valid(cmd_valid), .i_cmd_code(code),
        .i_status_cond(cond), .i_rd_req(rd_req), .o_cmd_ready(cmd_ready), .o_rd(rd),
        .o_resp_ready(resp_ready), .o_unknown_cmd(unk), .o_dev_reset(dev_rst));
    ivsr_host host (.i_clk(clk), .i_resp_ready(resp_ready), .i_rd(rd), .i_stall(stall),
        .i_clr(clr), .o_rd_req(rd_req), .o_buf(rx), .o_cnt(cnt));
    // Clock and random host stalls
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) stall <= 1'($random(seed));
    // Checksum over two data bytes
    function automatic logic [7:0] crc(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] c;
        c = ivsr_pkg::CRC_INIT ^ a;
        for (int k = 0; k < 16; k++) begin
            if (k == 8) c = c ^ b;
            c = c[7] ? {c[6:0], 1'b0} ^ ivsr_pkg::CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (miscompares == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One command pulse, also clearing the host's byte store
    task automatic cmd(input logic [15:0] c);
        @(posedge clk);
        #1 code = c;
        cmd_valid = 1'b1;
        clr = 1'b1;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        clr = 1'b0;
    endtask
    task automatic get(input int n);
        for (int k = 0; k < 300 && cnt < n; k++) @(posedge clk);
        #1;
        if (cnt < n) begin
            miscompares++;
            test_done();
        end
    endtask
    task automatic setc(input logic [31:0] c);
        @(posedge clk);
        #1 cond = c;
        sticky = sticky | (c & MASK);
        repeat (3) @(posedge clk);
    endtask
    task automatic rdstat(input logic [15:0] c, input logic [31:0] e);
        cmd(c);
        chk(unk, 32'h0);
        get(6);
        chk({rx[0], rx[1], rx[3], rx[4]}, e);
        chk({rx[2], rx[5]}, {crc(rx[0], rx[1]), crc(rx[3], rx[4])});
        if (c == ivsr_pkg::CMD_STATUS_CLEAR) sticky = cond & MASK;
    endtask
    // Main sequence
    initial begin
        seed = 27506;
        {rst_b, cmd_valid, clr, code, cond, sticky} = '0;
        {miscompares, checked} = '0;
        ver = '{VER.fw_major, VER.fw_minor, 8'h00, VER.fw_debug, VER.hw_major, 8'h00,
            VER.hw_minor, VER.proto_major, 8'h00, VER.proto_minor, 8'h00, 8'h00};
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        // Known answer of the expectation's checksum
        chk(crc(8'hBE, 8'hEF), 32'h92);
        // Version, with an unknown code arriving while it waits
        cmd(ivsr_pkg::CMD_VERSION);
        cmd(16'hD101);
        chk(unk, 32'h1);
        get(12);
        // Byte 10 is padding and is left unchecked
        for (i = 0; i < 12; i++) begin
            if (i % 3 == 2) chk(rx[i], crc(rx[i-2], rx[i-1]));
            else if (i != 10) chk(rx[i], ver[i]);
        end
        // Random conditions, plain and clearing reads
        for (i = 0; i < 8; i++) begin
            setc($random(seed));
            rdstat(i[0] ? ivsr_pkg::CMD_STATUS_CLEAR : ivsr_pkg::CMD_STATUS,
                sticky | (cond & ~MASK));
        end
        // Sticky bits outlive their fault, live bits follow it
        setc(32'hA5C30F0F);
        setc(32'h00000000);
        rdstat(ivsr_pkg::CMD_STATUS, sticky);
        rdstat(ivsr_pkg::CMD_STATUS, sticky);
        rdstat(ivsr_pkg::CMD_STATUS_CLEAR, sticky);
        rdstat(ivsr_pkg::CMD_STATUS, 32'h0);
        // Device reset clears sticky bits and ignores commands meanwhile
        setc(32'h00FF0000);
        setc(32'h00000000);
        cmd(ivsr_pkg::CMD_RESET);
        cmd(ivsr_pkg::CMD_STATUS);
        chk({dev_rst, cmd_ready}, 32'h2);
        for (i = 0; i < 40 && dev_rst; i++) @(posedge clk);
        #1 chk(cnt, 0);
        chk(dev_rst, 0);
        sticky = 32'h0;
        rdstat(ivsr_pkg::CMD_STATUS, 32'h0);
        test_done();
    end
endmodule
